// ### verilog/ipa_arbiter.v
// interrupt priority arbiter: levels, flags, enables and winner select
// assumes a core that samples the vector outputs each cycle and
// peripherals that raise one-cycle request pulses on sys_clk_i
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ipa_consts.vh"

module ipa_arbiter #(
    parameter NUM_SRC = `IPA_NUM_SRC
) (
    // clock and reset
    input  wire                      sys_clk_i,
    input  wire                      nrst_i,
    // register port
    input  wire [`IPA_ADDR_W-1:0]    reg_addr_i,
    input  wire [`IPA_DATA_W-1:0]    reg_wdata_i,
    input  wire                      reg_wr_i,
    input  wire                      reg_rd_i,
    output reg  [`IPA_DATA_W-1:0]    reg_rdata_o,
    // peripheral request pulses, bit n is source n
    input  wire [NUM_SRC-1:0]        src_event_i,
    // core side
    output reg                       irq_valid_o,
    output reg  [`IPA_VEC_W-1:0]     irq_vector_o,
    output reg  [`IPA_LVL_W-1:0]     irq_level_o,
    // summary interrupt
    output reg                       irq_o
);

    localparam NW  = `IPA_DATA_W;
    localparam SW  = `IPA_SRC_IDX_W;
    localparam LW  = `IPA_LVL_W;
    // sources per level word and per flag-style word
    localparam PW  = `IPA_DATA_W / `IPA_NIB_W;
    localparam FW  = `IPA_DATA_W;
    // word counts of the level bank and of each flag-style register
    localparam NLW = `IPA_NUM_REGS;
    localparam NFW = `IPA_WORDS_FL;

    // level storage, one three-bit field per source, kept flat
    reg  [NUM_SRC*LW-1:0]  level;
    wire [NUM_SRC*LW-1:0]  next_lvl_bank;
    reg  [NUM_SRC-1:0]     flag;
    reg  [NUM_SRC-1:0]     enable;
    reg  [NUM_SRC-1:0]     stat;
    reg  [NUM_SRC-1:0]     stat_en;

    // word-select decode helper
    function sel_word;
        input [`IPA_ADDR_W-1:0] addr;
        input [`IPA_ADDR_W-1:0] base;
        input integer           w;
        begin
            sel_word = (addr == base + w[`IPA_ADDR_W-1:0]);
        end
    endfunction

    // 16-bit slice of a source vector, padding past the end with zero
    function [NW-1:0] slice16;
        input [NUM_SRC-1:0] v;
        input integer       w;
        integer b;
        begin
            slice16 = `IPA_ZERO16;
            for (b = 0; b < NW; b = b + 1)
            begin
                if (w * NW + b < NUM_SRC)
                    slice16[b] = v[w * NW + b];
            end
        end
    endfunction

    // level field of one source out of the flat store
    function [LW-1:0] lvl_of;
        input [NUM_SRC*LW-1:0] bank;
        input integer          s;
        begin
            lvl_of = bank[s * LW +: LW];
        end
    endfunction

    // word selects, decoded once from the address
    wire [NLW-1:0] lvl_sel;
    wire [NFW-1:0] flag_sel;
    wire [NFW-1:0] fclr_sel;
    wire [NFW-1:0] en_sel;
    wire [NFW-1:0] sten_sel;
    genvar w;
    generate
        for (w = 0; w < NLW; w = w + 1)
        begin : g_lvl_sel
            assign lvl_sel[w] = sel_word(reg_addr_i, `IPA_LVL_OFF, w);
        end
        for (w = 0; w < NFW; w = w + 1)
        begin : g_fl_sel
            assign flag_sel[w] = sel_word(reg_addr_i, `IPA_FLAG_OFF, w);
            assign fclr_sel[w] = sel_word(reg_addr_i, `IPA_FCLR_OFF, w);
            assign en_sel[w]   = sel_word(reg_addr_i, `IPA_EN_OFF, w);
            assign sten_sel[w] = sel_word(reg_addr_i, `IPA_STAT_OFF, w);
        end
    endgenerate

    // register writes: levels
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1)
        begin : g_lvl
            // nibble bit three dropped
            assign next_lvl_bank[g * LW +: LW] =
                (reg_wr_i && lvl_sel[g / PW])
                    ? reg_wdata_i[(g % PW) * `IPA_NIB_W +: LW]
                    : level[g * LW +: LW];
        end
    endgenerate

    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            level <= {NUM_SRC{`IPA_LVL_DIS}};
        else
            level <= next_lvl_bank;
    end

    // flags, enables, status, status enable
    reg [NUM_SRC-1:0] next_flag;
    reg [NUM_SRC-1:0] next_enable;
    reg [NUM_SRC-1:0] next_stat;
    reg [NUM_SRC-1:0] next_stat_en;
    integer i;
    integer j;

    always @*
    begin
        next_flag    = flag;
        next_enable  = enable;
        next_stat    = stat;
        next_stat_en = stat_en;
        for (i = 0; i < NUM_SRC; i = i + 1)
        begin
            j = i / FW;
            if (reg_wr_i && flag_sel[j])
                next_flag[i] = reg_wdata_i[i % FW];
            if (reg_wr_i && en_sel[j])
                next_enable[i] = reg_wdata_i[i % FW];
            if (reg_wr_i && fclr_sel[j] && reg_wdata_i[i % FW])
                next_stat[i] = 1'b0;
            if (reg_wr_i && sten_sel[j])
                next_stat_en[i] = reg_wdata_i[i % FW];
            // event set regardless of enable, wins over clear
            if (src_event_i[i])
            begin
                next_flag[i] = 1'b1;
                next_stat[i] = 1'b1;
            end
        end
    end

    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            flag    <= {NUM_SRC{1'b0}};
            enable  <= {NUM_SRC{1'b0}};
            stat    <= {NUM_SRC{1'b0}};
            stat_en <= {NUM_SRC{1'b0}};
        end
        else
        begin
            flag    <= next_flag;
            enable  <= next_enable;
            stat    <= next_stat;
            stat_en <= next_stat_en;
        end
    end

    // read mux, one cycle after the strobe
    reg [NW-1:0] rd_mux;
    integer k;

    always @*
    begin
        rd_mux = `IPA_ZERO16;
        for (k = 0; k < NUM_SRC; k = k + 1)
        begin
            if (lvl_sel[k / PW])
                // bit three of each nibble reads zero
                rd_mux[(k % PW) * `IPA_NIB_W +: `IPA_NIB_W] =
                    {`IPA_NIB_PAD, lvl_of(level, k)};
        end
        for (k = 0; k < NFW; k = k + 1)
        begin
            if (flag_sel[k])
                rd_mux = slice16(flag, k);
            if (en_sel[k])
                rd_mux = slice16(enable, k);
            if (sten_sel[k])
                rd_mux = slice16(stat_en, k);
            if (fclr_sel[k])
                rd_mux = slice16(stat, k);
        end
    end

    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= `IPA_ZERO16;
        else if (reg_rd_i)
            reg_rdata_o <= rd_mux;
        else
            reg_rdata_o <= `IPA_ZERO16;
    end

    // winner search: level first, lowest number on ties
    reg                    next_valid;
    reg [`IPA_LVL_W-1:0]   next_level;
    reg [SW-1:0]           next_src;
    integer m;

    always @*
    begin
        next_valid = 1'b0;
        next_level = `IPA_LVL_DIS;
        next_src   = {SW{1'b0}};
        // ascending scan, strict compare keeps lower number on tie
        for (m = 0; m < NUM_SRC; m = m + 1)
        begin
            // level zero means disabled
            if (flag[m] && enable[m] && lvl_of(level, m) != `IPA_LVL_DIS &&
                (!next_valid || lvl_of(level, m) > next_level))
            begin
                next_valid = 1'b1;
                next_level = lvl_of(level, m);
                next_src   = m[SW-1:0];
            end
        end
    end

    // outputs to core, registered
    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            irq_valid_o  <= 1'b0;
            irq_vector_o <= {`IPA_VEC_W{1'b0}};
            irq_level_o  <= `IPA_LVL_DIS;
            irq_o        <= 1'b0;
        end
        else
        begin
            irq_valid_o  <= next_valid;
            irq_vector_o <= next_valid ? next_src + `IPA_VEC_BASE
                                       : {`IPA_VEC_W{1'b0}};
            irq_level_o  <= next_level;
            irq_o        <= |(next_stat & next_stat_en);
        end
    end

endmodule // ipa_arbiter

`default_nettype wire

// ### inc/ipa_consts.vh
// constants for the interrupt priority arbiter
// assumes inclusion by the arbiter design file and its port checker
`ifndef IPA_CONSTS_VH
`define IPA_CONSTS_VH

`define IPA_NUM_SRC      54
`define IPA_LVL_W        3
`define IPA_NIB_W        4
`define IPA_VEC_W        6
`define IPA_VEC_BASE     6'h08
`define IPA_NUM_REGS     14
`define IPA_ADDR_W       5
`define IPA_DATA_W       16
`define IPA_LVL_OFF      5'h00
`define IPA_FLAG_OFF     5'h0E
`define IPA_FCLR_OFF     5'h12
`define IPA_EN_OFF       5'h16
`define IPA_STAT_OFF     5'h1A
`define IPA_SRC_IDX_W    6
`define IPA_LVL_DIS      3'h0
`define IPA_NIB_PAD      1'h0
`define IPA_ZERO16       16'h0000
`define IPA_WORDS_FL     4

`endif

// ### sim/ipa_arbiter_sva.sv
// port checker for the interrupt priority arbiter
// assumes binding onto every ipa_arbiter instance
`timescale 1ns/10ps
`default_nettype none
`include "ipa_consts.vh"
module ipa_arbiter_sva #(parameter NUM_SRC = `IPA_NUM_SRC) (
    input wire logic                    sys_clk_i,
    input wire logic                    nrst_i,
    input wire logic [`IPA_ADDR_W-1:0]  reg_addr_i,
    input wire logic [`IPA_DATA_W-1:0]  reg_wdata_i,
    input wire logic                    reg_wr_i,
    input wire logic                    reg_rd_i,
    input wire logic [`IPA_DATA_W-1:0]  reg_rdata_o,
    input wire logic [NUM_SRC-1:0]      src_event_i,
    input wire logic                    irq_valid_o,
    input wire logic [`IPA_VEC_W-1:0]   irq_vector_o,
    input wire logic [`IPA_LVL_W-1:0]   irq_level_o,
    input wire logic                    irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    chk_vec_range:
    assert property (irq_valid_o |-> irq_vector_o inside {[8:61]})
        else $error("vector out of range");
    chk_idle_zero:
    assert property (!irq_valid_o |-> irq_vector_o == 0 && irq_level_o == 0)
        else $error("idle outputs not zero");
    chk_level_nonzero:
    assert property (irq_valid_o |-> irq_level_o != 0)
        else $error("winner at level zero");
    chk_rdata_pulse:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
        else $error("read data outside read slot");
    chk_nibble_pad:
    assert property ($past(reg_rd_i) && $past(reg_addr_i) < 14
        |-> (reg_rdata_o & 16'h8888) == 0) else $error("pad bit set");
    chk_unmapped_zero:
    assert property ($past(reg_rd_i) && $past(reg_addr_i) > 29
        |-> reg_rdata_o == 0) else $error("unmapped read not zero");
    chk_irq_cause:
    assert property ($rose(irq_o) |-> $past(|src_event_i || reg_wr_i)
        || $past(|src_event_i || reg_wr_i, 2)) else $error("irq no cause");
    chk_valid_cause:
    assert property ($rose(irq_valid_o) |-> $past(|src_event_i || reg_wr_i)
        || $past(|src_event_i || reg_wr_i, 2)) else $error("winner no cause");
    cov_top_level: cover property (irq_valid_o && irq_level_o == 3'h7);
    cov_irq: cover property (irq_o);
    cov_read: cover property (reg_rdata_o != 0);
endmodule // ipa_arbiter_sva
bind ipa_arbiter ipa_arbiter_sva #(.NUM_SRC(NUM_SRC)) u_sva (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .src_event_i(src_event_i),
    .irq_valid_o(irq_valid_o), .irq_vector_o(irq_vector_o),
    .irq_level_o(irq_level_o), .irq_o(irq_o));
`default_nettype wire

// ### sim/ipa_core_model.sv
// core model: fetches the offered vector and level each cycle
// assumes the arbiter clock and reset
`timescale 1ns/10ps
`default_nettype none
module ipa_core_model (
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        valid_i,
    input wire logic [5:0]  vector_i,
    input wire logic [2:0]  level_i,
    output var logic [5:0]  fetch_vec_o,
    output var logic [2:0]  fetch_lvl_o
);
    always @(posedge sys_clk_i)
    begin
        fetch_vec_o <= (nrst_i && valid_i) ? vector_i : 6'h00;
        fetch_lvl_o <= (nrst_i && valid_i) ? level_i : 3'h0;
    end
endmodule // ipa_core_model
`default_nettype wire

// ### sim/ipa_arbiter_tb_top.sv
// self-checking bench for the interrupt priority arbiter
// assumes the arbiter and a core model on one 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
module ipa_arbiter_tb_top;
    logic        sys_clk_i;
    logic        nrst_i;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [53:0] ev;
    logic        valid;
    logic        irq;
    logic [5:0]  vec;
    logic [5:0]  fvec;
    logic [2:0]  lvl;
    logic [2:0]  flvl;
    int          bad_count;
    int          samples_checked;
    ipa_arbiter dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .src_event_i(ev),
        .irq_valid_o(valid), .irq_vector_o(vec), .irq_level_o(lvl),
        .irq_o(irq));
    ipa_core_model core (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .valid_i(valid), .vector_i(vec), .level_i(lvl),
        .fetch_vec_o(fvec), .fetch_lvl_o(flvl));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    task automatic fire(input logic [53:0] m);
        @(posedge sys_clk_i);
        ev <= m;
        @(posedge sys_clk_i);
        ev <= '0;
    endtask
    task automatic win(input logic v, input logic [5:0] x,
        input logic [2:0] l);
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk("winner", {6'h00, v, x, l}, {6'h00, valid, fvec, flvl});
    endtask
    task automatic chk_irq(input logic e);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("irq", {15'h0000, e}, {15'h0000, irq});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        nrst_i = 1'b0;
        addr = 5'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        ev = '0;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        wr_reg(5'h00, 16'hffff);
        rd_reg(5'h00, 16'h7777);
        rd_reg(5'h1f, 16'h0000);
        wr_reg(5'h00, 16'h0300);
        wr_reg(5'h01, 16'h0030);
        wr_reg(5'h16, 16'h87ff);
        fire(54'h24);
        win(1'b1, 6'h0a, 3'h3);
        wr_reg(5'h03, 16'h7000);
        fire(54'h8000);
        win(1'b1, 6'h17, 3'h7);
        wr_reg(5'h03, 16'h0000);
        win(1'b1, 6'h0a, 3'h3);
        wr_reg(5'h02, 16'h7000);
        fire(54'h0800);
        win(1'b1, 6'h0a, 3'h3);
        rd_reg(5'h0e, 16'h8824);
        rd_reg(5'h12, 16'h8824);
        chk_irq(1'b0);
        wr_reg(5'h1a, 16'h0800);
        chk_irq(1'b1);
        wr_reg(5'h12, 16'h0800);
        chk_irq(1'b0);
        wr_reg(5'h0e, 16'h0000);
        win(1'b0, 6'h00, 3'h0);
        stop_test();
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk_i);
        bad_count++;
        stop_test();
    end
endmodule // ipa_arbiter_tb_top
`default_nettype wire
